/* File: mul16_decoder_model.sv */
// ----------------------------------------------------------------------------
// issue side: decoder and register port driver
// ----------------------------------------------------------------------------
module mul16_decoder_model (
   input  wire logic                  clk_i,
   output logic                       op_valid_o,
   output mul16_pkg::mul_mode_t       mode_o,
   output logic                       mixed_o,
   output logic [2:0]                 src0_idx_o,
   output logic                       src0_high_o,
   output logic [2:0]                 src1_idx_o,
   output logic                       src1_high_o,
   output logic                       dest_full_o,
   output logic [2:0]                 dest_idx_o,
   output logic                       dest_high_o,
   output logic                       rnd_o,
   output logic                       clr_o,
   output logic                       wr_o,
   output logic [2:0]                 wr_idx_o,
   output logic [31:0]                wr_data_o,
   output logic                       rd_o,
   output logic [2:0]                 rd_idx_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      mode_o = mul16_pkg::mode_default;
      {op_valid_o, mixed_o, src0_idx_o, src0_high_o, src1_idx_o, src1_high_o} = '0;
      {dest_full_o, dest_idx_o, dest_high_o, rnd_o, clr_o} = '0;
      {wr_o, wr_idx_o, wr_data_o, rd_o, rd_idx_o} = '0;
   end

   // only the option combinations the bench asks for, refused ones included
   task automatic issue(input logic [3:0] m, input logic x, input logic [3:0] a, input logic [3:0] b,
                        input logic [4:0] d, input logic r);
      @(posedge clk_i);
      op_valid_o <= 1'b1;
      mode_o <= mul16_pkg::mul_mode_t'(m);
      mixed_o <= x;
      {src0_idx_o, src0_high_o} <= a;
      {src1_idx_o, src1_high_o} <= b;
      {dest_full_o, dest_idx_o, dest_high_o} <= d;
      rnd_o <= r;
      @(posedge clk_i);
      op_valid_o <= 1'b0;
      // fields no longer qualified: show a changed pattern
      {mixed_o, src0_idx_o, src0_high_o, src1_idx_o, src1_high_o} <= ~{x, a, b};
      {dest_full_o, dest_idx_o, dest_high_o} <= ~d;
   endtask : issue

   task automatic rf_write(input logic [2:0] i, input logic [31:0] v);
      @(posedge clk_i);
      wr_o <= 1'b1;
      wr_idx_o <= i;
      wr_data_o <= v;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wr_data_o <= ~v;
   endtask : rf_write

   task automatic rf_read(input logic [2:0] i);
      @(posedge clk_i);
      rd_o <= 1'b1;
      rd_idx_o <= i;
      @(posedge clk_i);
      rd_o <= 1'b0;
      rd_idx_o <= ~i;
   endtask : rf_read

   task automatic clear_sticky;
      @(posedge clk_i);
      clr_o <= 1'b1;
      @(posedge clk_i);
      clr_o <= 1'b0;
   endtask : clear_sticky

endmodule : mul16_decoder_model

/* File: mul16_operand_multiplier.sv */
// Decided for this implementation: the register offsets and strobed register access.
module mul16_operand_multiplier (
   input  wire logic                          clk_i,
   input  wire logic                          srst_i,
   input  wire logic                          op_valid_i,
   input  wire mul16_pkg::mul_mode_t          mode_i,
   input  wire logic                          mixed_i,
   input  wire logic [mul16_pkg::IDX_W-1:0]   src0_idx_i,
   input  wire logic                          src0_high_i,
   input  wire logic [mul16_pkg::IDX_W-1:0]   src1_idx_i,
   input  wire logic                          src1_high_i,
   input  wire logic                          dest_full_i,
   input  wire logic [mul16_pkg::IDX_W-1:0]   dest_idx_i,
   input  wire logic                          dest_high_i,
   input  wire logic                          rounding_kind_bit_i,
   input  wire logic                          sticky_clear_i,
   input  wire logic                          rf_wr_i,
   input  wire logic [mul16_pkg::IDX_W-1:0]   rf_wr_idx_i,
   input  wire logic [31:0]                   rf_wr_data_i,
   input  wire logic                          rf_rd_i,
   input  wire logic [mul16_pkg::IDX_W-1:0]   rf_rd_idx_i,
   output logic      [31:0]                   rf_rd_data_o,
   output logic                               done_o,
   output logic                               illegal_o,
   output logic      [31:0]                   result_o,
   output logic                               unit_one_o,
   output logic                               sat_flag_o,
   output logic                               sticky_saturation_flag_o
);

   // ------------------------------------------------------------------------
   // data register file
   // ------------------------------------------------------------------------
   logic [31:0] rf_q [mul16_pkg::NUM_REGS];

   wire  [31:0] src0_word = rf_q[src0_idx_i];
   wire  [31:0] src1_word = rf_q[src1_idx_i];
   wire  [31:0] dest_word = rf_q[dest_idx_i];
   wire  [15:0] op0       = src0_high_i ? src0_word[31:16] : src0_word[15:0];
   wire  [15:0] op1       = src1_high_i ? src1_word[31:16] : src1_word[15:0];

   // ------------------------------------------------------------------------
   // option decode
   // ------------------------------------------------------------------------
   wire is_default = mode_i == mul16_pkg::mode_default;
   wire is_ufrac   = mode_i == mul16_pkg::unsigned_fraction;
   wire is_sint    = mode_i == mul16_pkg::signed_integer;
   wire is_uint    = mode_i == mul16_pkg::unsigned_integer;
   wire is_schop   = mode_i == mul16_pkg::signed_chop_mode;
   wire is_uchop   = mode_i == mul16_pkg::unsigned_chop_mode;
   wire is_dround  = mode_i == mul16_pkg::double_and_round;
   wire is_ssint   = mode_i == mul16_pkg::scaled_signed_integer;
   wire is_ihigh   = mode_i == mul16_pkg::integer_high_extract;
   wire mode_ok    = is_default | is_ufrac | is_sint | is_uint | is_schop | is_uchop
                   | is_dround | is_ssint | is_ihigh;

   // unit is fixed by the destination lane or register parity
   wire unit_one   = dest_full_i ? dest_idx_i[0] : dest_high_i;
   wire full_ok    = is_default | is_ufrac | is_sint | is_ssint;
   wire mixed_ok   = ~mixed_i | unit_one;
   wire legal      = mode_ok & (~dest_full_i | full_ok) & mixed_ok;
   wire do_op      = op_valid_i & legal;

   // ------------------------------------------------------------------------
   // product formation
   // ------------------------------------------------------------------------
   wire uns_ops    = is_ufrac | is_uint;
   wire s0_signed  = mixed_i | ~uns_ops;
   wire s1_signed  = ~mixed_i & ~uns_ops;
   wire signed [mul16_pkg::OPX_W-1:0]  op0_x = {s0_signed & op0[15], op0};
   wire signed [mul16_pkg::OPX_W-1:0]  op1_x = {s1_signed & op1[15], op1};
   wire signed [mul16_pkg::PROD_W-1:0] prod  = op0_x * op1_x;

   // left-shift correction only for signed fraction forms without mixed sign
   wire frac_corr  = (is_default | is_schop | is_uchop | is_dround) & ~mixed_i;
   wire dbl        = is_dround | is_ssint;
   wire [1:0] shamt = {1'b0, frac_corr} + {1'b0, dbl};
   wire signed [mul16_pkg::WIDE_W-1:0] prod_w = mul16_pkg::WIDE_W'(prod);
   wire signed [mul16_pkg::WIDE_W-1:0] wide   = prod_w <<< shamt;

   // half results of fraction forms and high extract are cut at bit 16
   wire frac_sel   = ~dest_full_i & ~(is_sint | is_uint | is_ssint);
   wire round_en   = frac_sel & ~(is_schop | is_uchop);
   wire uns_sat    = is_ufrac | is_uint | is_uchop;
   wire biased     = rounding_kind_bit_i == mul16_pkg::RND_BIASED;

   logic [31:0] res;
   logic        sat;

   mul16_round_unit u_round (
      .wide_i     (wide),
      .frac_i     (frac_sel),
      .round_en_i (round_en),
      .biased_i   (biased),
      .uns_i      (uns_sat),
      .full_i     (dest_full_i),
      .res_o      (res),
      .sat_o      (sat)
   );

   // half results land in their own lane, the other lane is kept
   wire [31:0] dest_new = dest_full_i ? res
                        : (dest_high_i ? {res[15:0], dest_word[15:0]}
                                       : {dest_word[31:16], res[15:0]});

   // ------------------------------------------------------------------------
   // register file update
   // ------------------------------------------------------------------------
   for (genvar i = 0; i < mul16_pkg::NUM_REGS; i++) begin : g_rf
      wire hit_op = do_op & (dest_idx_i == (mul16_pkg::IDX_W)'(i));
      wire hit_wr = rf_wr_i & (rf_wr_idx_i == (mul16_pkg::IDX_W)'(i));
      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            rf_q[i] <= mul16_pkg::RF_RESET;
         end else if (hit_op) begin
            rf_q[i] <= dest_new;
         end else if (hit_wr) begin
            rf_q[i] <= rf_wr_data_i;
         end
      end
   end

   // ------------------------------------------------------------------------
   // status and outputs
   // ------------------------------------------------------------------------
   logic [31:0] rd_data_q;
   logic        done_q;
   logic        illegal_q;
   logic [31:0] result_q;
   logic        unit_one_q;
   logic        sat_flag_q;
   logic        sticky_q;

   wire  [31:0] rd_data_d = rf_rd_i ? rf_q[rf_rd_idx_i] : rd_data_q;
   wire  [31:0] result_d  = do_op ? res : result_q;
   wire         unit_d    = do_op ? unit_one : unit_one_q;
   wire         sat_d     = do_op ? sat : sat_flag_q;
   // a new saturation wins over a clear in the same cycle
   wire         sticky_d  = (do_op & sat) | (sticky_q & ~sticky_clear_i);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rd_data_q  <= mul16_pkg::RF_RESET;
         done_q     <= 1'b0;
         illegal_q  <= 1'b0;
         result_q   <= mul16_pkg::RF_RESET;
         unit_one_q <= 1'b0;
         sat_flag_q <= mul16_pkg::FLAG_RESET;
         sticky_q   <= mul16_pkg::FLAG_RESET;
      end else begin
         rd_data_q  <= rd_data_d;
         done_q     <= do_op;
         illegal_q  <= op_valid_i & ~legal;
         result_q   <= result_d;
         unit_one_q <= unit_d;
         sat_flag_q <= sat_d;
         sticky_q   <= sticky_d;
      end
   end

   assign rf_rd_data_o             = rd_data_q;
   assign done_o                   = done_q;
   assign illegal_o                = illegal_q;
   assign result_o                 = result_q;
   assign unit_one_o               = unit_one_q;
   assign sat_flag_o               = sat_flag_q;
   assign sticky_saturation_flag_o = sticky_q;

   // ------------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------------
   wire [15:0] chop_ref   = wide[31:16];
   wire [15:0] uint_ref   = (prod > 34'sh0_0000_FFFF) ? 16'hFFFF : prod[15:0];
   wire        neg_sq     = (op0 == mul16_pkg::FRAC_NEG_ONE) & (op1 == mul16_pkg::FRAC_NEG_ONE);
   wire [15:0] sint16_ref = (prod > 34'sh0_0000_7FFF) ? 16'h7FFF
                          : ((prod < 34'sh3_FFFF_8000) ? 16'h8000 : prod[15:0]);
   wire [15:0] dround_ref = prod[29:14] + {15'h0000, prod[13]};

   property p_low_unit_keeps_high;
      @(posedge clk_i) disable iff (srst_i)
      do_op & ~dest_full_i & ~dest_high_i
      |=> ~unit_one_o && (rf_q[$past(dest_idx_i)][31:16] == $past(dest_word[31:16]));
   endproperty
   a_low_unit_keeps_high : assert property (p_low_unit_keeps_high)
      else $error("low half write disturbed the high half");

   property p_full_parity_unit;
      @(posedge clk_i) disable iff (srst_i)
      do_op & dest_full_i |=> done_o && (unit_one_o == $past(dest_idx_i[0]));
   endproperty
   a_full_parity_unit : assert property (p_full_parity_unit)
      else $error("full destination used the wrong unit");

   property p_mixed_needs_unit_one;
      @(posedge clk_i) disable iff (srst_i)
      op_valid_i & mixed_i & ~unit_one & ~rf_wr_i
      |=> illegal_o && !done_o && (rf_q[$past(dest_idx_i)] == $past(dest_word));
   endproperty
   a_mixed_needs_unit_one : assert property (p_mixed_needs_unit_one)
      else $error("mixed option accepted on unit zero");

   property p_source_kept;
      @(posedge clk_i) disable iff (srst_i)
      do_op & ~rf_wr_i & (src0_idx_i != dest_idx_i)
      |=> rf_q[$past(src0_idx_i)] == $past(src0_word);
   endproperty
   a_source_kept : assert property (p_source_kept)
      else $error("source register changed");

   property p_full_illegal_mode;
      @(posedge clk_i) disable iff (srst_i)
      op_valid_i & dest_full_i & (is_uint | is_schop | is_uchop | is_dround | is_ihigh)
      |=> illegal_o && !done_o;
   endproperty
   a_full_illegal_mode : assert property (p_full_illegal_mode)
      else $error("option not allowed for full destination was executed");

   property p_neg_one_squared;
      @(posedge clk_i) disable iff (srst_i)
      do_op & is_default & ~mixed_i & neg_sq
      |=> sat_flag_o && sticky_saturation_flag_o
          && ($past(dest_full_i) ? (result_o == mul16_pkg::FRAC_MAX32)
                                 : (result_o[15:0] == mul16_pkg::FRAC_MAX16));
   endproperty
   a_neg_one_squared : assert property (p_neg_one_squared)
      else $error("minus one squared did not saturate");

   property p_chop_no_round;
      @(posedge clk_i) disable iff (srst_i)
      do_op & is_schop & ~dest_full_i |=> sat_flag_o || (result_o[15:0] == $past(chop_ref));
   endproperty
   a_chop_no_round : assert property (p_chop_no_round)
      else $error("signed chop result was rounded");

   property p_unbiased_even;
      @(posedge clk_i) disable iff (srst_i)
      do_op & is_default & ~dest_full_i & ~biased & (wide[15:0] == mul16_pkg::ROUND_HALF)
      |=> sat_flag_o || !result_o[0];
   endproperty
   a_unbiased_even : assert property (p_unbiased_even)
      else $error("unbiased tie did not round to even");

   property p_uint_half;
      @(posedge clk_i) disable iff (srst_i)
      do_op & is_uint & ~mixed_i |=> result_o[15:0] == $past(uint_ref);
   endproperty
   a_uint_half : assert property (p_uint_half)
      else $error("unsigned integer half result wrong");

   property p_full_sint;
      @(posedge clk_i) disable iff (srst_i)
      do_op & is_sint & dest_full_i |=> !sat_flag_o && (result_o == $past(prod[31:0]));
   endproperty
   a_full_sint : assert property (p_full_sint)
      else $error("signed integer full result wrong");

   property p_sticky_follows;
      @(posedge clk_i) disable iff (srst_i)
      sat_flag_o & done_o |-> sticky_saturation_flag_o;
   endproperty
   a_sticky_follows : assert property (p_sticky_follows)
      else $error("sticky flag missed a saturation");

   property p_flag_hold;
      @(posedge clk_i) disable iff (srst_i)
      !do_op |=> $stable(sat_flag_o) && $stable(result_o);
   endproperty
   a_flag_hold : assert property (p_flag_hold)
      else $error("flag changed without an operation");

   property p_full_default_unrounded;
      @(posedge clk_i) disable iff (srst_i)
      do_op & dest_full_i & is_default & ~mixed_i & ~neg_sq
      |=> !sat_flag_o && (result_o == $past(wide[31:0]));
   endproperty
   a_full_default_unrounded : assert property (p_full_default_unrounded)
      else $error("full default result was rounded or clipped");

   property p_full_ufrac;
      @(posedge clk_i) disable iff (srst_i)
      do_op & dest_full_i & is_ufrac & ~mixed_i |=> !sat_flag_o && (result_o == $past(prod[31:0]));
   endproperty
   a_full_ufrac : assert property (p_full_ufrac)
      else $error("unsigned full result wrong");

   property p_sint_half;
      @(posedge clk_i) disable iff (srst_i)
      do_op & is_sint & ~dest_full_i & ~mixed_i |=> result_o[15:0] == $past(sint16_ref);
   endproperty
   a_sint_half : assert property (p_sint_half)
      else $error("signed integer half result wrong");

   property p_double_round;
      @(posedge clk_i) disable iff (srst_i)
      do_op & is_dround & ~mixed_i & ~dest_full_i & biased
      |=> sat_flag_o || (result_o[15:0] == $past(dround_ref));
   endproperty
   a_double_round : assert property (p_double_round)
      else $error("double and round result wrong");

   property p_sticky_holds;
      @(posedge clk_i) disable iff (srst_i)
      sticky_saturation_flag_o & ~sticky_clear_i |=> sticky_saturation_flag_o;
   endproperty
   a_sticky_holds : assert property (p_sticky_holds)
      else $error("sticky flag dropped without a clear");

   property p_illegal_keeps_dest;
      @(posedge clk_i) disable iff (srst_i)
      op_valid_i & ~legal & ~rf_wr_i
      |=> illegal_o && !done_o && (rf_q[$past(dest_idx_i)] == $past(dest_word));
   endproperty
   a_illegal_keeps_dest : assert property (p_illegal_keeps_dest)
      else $error("refused operation changed the destination");

   property p_high_unit_keeps_low;
      @(posedge clk_i) disable iff (srst_i)
      do_op & ~dest_full_i & dest_high_i
      |=> unit_one_o && (rf_q[$past(dest_idx_i)][15:0] == $past(dest_word[15:0]));
   endproperty
   a_high_unit_keeps_low : assert property (p_high_unit_keeps_low)
      else $error("high half write disturbed the low half");

endmodule : mul16_operand_multiplier

/* File: mul16_round_unit.sv */
// ----------------------------------------------------------------------------
// shared constants
// ----------------------------------------------------------------------------
package mul16_pkg;

   // option selected for the multiply
   typedef enum logic [3:0] {
      mode_default,
      unsigned_fraction,
      signed_integer,
      unsigned_integer,
      signed_chop_mode,
      unsigned_chop_mode,
      double_and_round,
      scaled_signed_integer,
      integer_high_extract
   } mul_mode_t;

   localparam int unsigned DATA_W    = 32;
   localparam int unsigned HALF_W    = 16;
   localparam int unsigned OPX_W     = 17;
   localparam int unsigned PROD_W    = 34;
   localparam int unsigned WIDE_W    = 40;
   localparam int unsigned NUM_REGS  = 8;
   localparam int unsigned IDX_W     = 3;
   localparam int unsigned ROUND_POS = 16;

   localparam logic [15:0] ROUND_HALF = 16'h8000;
   localparam logic [15:0] FRAC_NEG_ONE = 16'h8000;
   localparam logic [15:0] FRAC_MAX16   = 16'h7FFF;
   localparam logic [31:0] FRAC_MAX32   = 32'h7FFF_FFFF;

   localparam logic [39:0] S16_MAX = 40'h00_0000_7FFF;
   localparam logic [39:0] S16_MIN = 40'hFF_FFFF_8000;
   localparam logic [39:0] U16_MAX = 40'h00_0000_FFFF;
   localparam logic [39:0] S32_MAX = 40'h00_7FFF_FFFF;
   localparam logic [39:0] S32_MIN = 40'hFF_8000_0000;
   localparam logic [39:0] U32_MAX = 40'h00_FFFF_FFFF;
   localparam logic [39:0] U_MIN   = 40'h00_0000_0000;

   // level of the rounding kind bit that selects biased rounding
   localparam logic RND_BIASED = 1'b1;

   localparam logic [31:0] RF_RESET   = 32'h0000_0000;
   localparam logic        FLAG_RESET = 1'b0;

endpackage : mul16_pkg

// ----------------------------------------------------------------------------
// rounding, extraction and saturation of the scaled product
// ----------------------------------------------------------------------------
module mul16_round_unit (
   input  wire logic signed [39:0] wide_i,
   input  wire logic               frac_i,
   input  wire logic               round_en_i,
   input  wire logic               biased_i,
   input  wire logic               uns_i,
   input  wire logic               full_i,
   output logic [31:0]             res_o,
   output logic                    sat_o
);

   logic signed [39:0] trunc_w;
   logic        [15:0] low_w;
   logic               inc_w;
   logic signed [39:0] rounded_w;
   logic signed [39:0] picked_w;
   logic signed [39:0] max_w;
   logic signed [39:0] min_w;
   logic               over_w;
   logic               under_w;
   logic        [31:0] clamp_w;

   // bits below the cut are dropped when rounding is off
   assign trunc_w   = wide_i >>> mul16_pkg::ROUND_POS;
   assign low_w     = wide_i[15:0];
   // unbiased: an exact half rounds toward the even result
   assign inc_w     = round_en_i & low_w[15] & (biased_i | (|low_w[14:0]) | trunc_w[0]);
   assign rounded_w = trunc_w + 40'(inc_w);
   assign picked_w  = frac_i ? rounded_w : wide_i;

   assign max_w   = full_i ? (uns_i ? mul16_pkg::U32_MAX : mul16_pkg::S32_MAX)
                           : (uns_i ? mul16_pkg::U16_MAX : mul16_pkg::S16_MAX);
   assign min_w   = uns_i ? mul16_pkg::U_MIN : (full_i ? mul16_pkg::S32_MIN : mul16_pkg::S16_MIN);
   assign over_w  = picked_w > max_w;
   assign under_w = picked_w < min_w;
   assign clamp_w = over_w ? max_w[31:0] : (under_w ? min_w[31:0] : picked_w[31:0]);

   assign res_o = full_i ? clamp_w : {16'h0000, clamp_w[15:0]};
   assign sat_o = over_w | under_w;

endmodule : mul16_round_unit

/* File: test_mul16_operand_multiplier.sv */
module test_mul16_operand_multiplier;
   timeunit 1ns;
   timeprecision 1ns;

   logic                 clk_i, srst_i, op_valid, mixed, s0_hi, s1_hi, d_full, d_hi, rnd, clr;
   logic                 wr, rd_s, done, illegal, unit_one, sat, sticky, exp_sticky, last_sat;
   logic [2:0]           s0_idx, s1_idx, d_idx, wr_idx, rd_idx;
   logic [31:0]          wr_data, rd_data, result, last_res;
   mul16_pkg::mul_mode_t mode;
   int                   fails = 0;
   int                   comparisons = 0;

   mul16_operand_multiplier mul16_operand_multiplier_inst (
      .clk_i(clk_i), .srst_i(srst_i), .op_valid_i(op_valid), .mode_i(mode), .mixed_i(mixed),
      .src0_idx_i(s0_idx), .src0_high_i(s0_hi), .src1_idx_i(s1_idx), .src1_high_i(s1_hi),
      .dest_full_i(d_full), .dest_idx_i(d_idx), .dest_high_i(d_hi), .rounding_kind_bit_i(rnd),
      .sticky_clear_i(clr), .rf_wr_i(wr), .rf_wr_idx_i(wr_idx), .rf_wr_data_i(wr_data),
      .rf_rd_i(rd_s), .rf_rd_idx_i(rd_idx), .rf_rd_data_o(rd_data), .done_o(done),
      .illegal_o(illegal), .result_o(result), .unit_one_o(unit_one), .sat_flag_o(sat),
      .sticky_saturation_flag_o(sticky));

   mul16_decoder_model mul16_decoder_model_inst (
      .clk_i(clk_i), .op_valid_o(op_valid), .mode_o(mode), .mixed_o(mixed),
      .src0_idx_o(s0_idx), .src0_high_o(s0_hi), .src1_idx_o(s1_idx), .src1_high_o(s1_hi),
      .dest_full_o(d_full), .dest_idx_o(d_idx), .dest_high_o(d_hi), .rnd_o(rnd), .clr_o(clr),
      .wr_o(wr), .wr_idx_o(wr_idx), .wr_data_o(wr_data), .rd_o(rd_s), .rd_idx_o(rd_idx));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // modes: 0 default 1 ufrac 2 sint 3 uint 4 schop 5 uchop 6 dbl 7 ssint 8 hiext
   // a, b = {reg, high}; d = {full, reg, high}
   task automatic op(input logic [3:0] m, input logic x, input logic [3:0] a, input logic [3:0] b,
                     input logic [4:0] d, input logic r, input logic [31:0] e, input logic s);
      mul16_decoder_model_inst.issue(m, x, a, b, d, r);
      @(negedge clk_i);
      exp_sticky = exp_sticky | s;
      chk("done", 32'h1, {31'h0, done});
      chk("result", e, result);
      chk("sat", {31'h0, s}, {31'h0, sat});
      chk("sticky", {31'h0, exp_sticky}, {31'h0, sticky});
      chk("unit", {31'h0, d[4] ? d[1] : d[0]}, {31'h0, unit_one});
      last_res = e;
      last_sat = s;
   endtask : op

   task automatic bad(input logic [3:0] m, input logic x, input logic [3:0] a, input logic [4:0] d);
      mul16_decoder_model_inst.issue(m, x, a, 4'h3, d, 1'b1);
      @(negedge clk_i);
      chk("refused", 32'h2, {30'h0, illegal, done});
      chk("kept", last_res, result);
      chk("kept_sat", {31'h0, last_sat}, {31'h0, sat});
   endtask : bad

   task automatic rd(input logic [2:0] i, input logic [31:0] e);
      mul16_decoder_model_inst.rf_read(i);
      @(negedge clk_i);
      chk("reg", e, rd_data);
   endtask : rd

   task automatic wrap_up;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #(5000 * 100);
      fails++;
      wrap_up();
   end

   initial begin
      srst_i = 1'b1;
      exp_sticky = 1'b0;
      repeat (5) @(posedge clk_i);
      srst_i <= 1'b0;
      @(negedge clk_i);
      chk("rst", 32'h0, result);
      chk("rst_flags", 32'h0, {27'h0, done, illegal, unit_one, sat, sticky});
      rd(2, 32'h0);
      $display("test reset done");
      mul16_decoder_model_inst.rf_write(0, 32'h4000_8000);
      mul16_decoder_model_inst.rf_write(1, 32'h0003_0001);
      mul16_decoder_model_inst.rf_write(3, 32'hAAAA_5555);
      op(0, 0, 0, 0, 5'h06, 1, 32'h7FFF, 1);
      rd(3, 32'hAAAA_7FFF);
      op(0, 0, 1, 1, 5'h07, 1, 32'h2000, 0);
      rd(3, 32'h2000_7FFF);
      rd(0, 32'h4000_8000);
      $display("test lanes done");
      op(0, 0, 1, 2, 5'h04, 1, 32'h0001, 0);
      op(0, 0, 1, 2, 5'h04, 0, 32'h0000, 0);
      op(0, 0, 1, 3, 5'h04, 0, 32'h0002, 0);
      op(4, 0, 1, 3, 5'h04, 1, 32'h0001, 0);
      op(0, 0, 1, 3, 5'h18, 1, 32'h0001_8000, 0);
      op(2, 0, 0, 3, 5'h1A, 1, 32'hFFFE_8000, 0);
      op(2, 0, 0, 3, 5'h04, 0, 32'h8000, 1);
      op(2, 0, 3, 3, 5'h04, 1, 32'h0009, 0);
      op(3, 0, 0, 3, 5'h04, 1, 32'hFFFF, 1);
      op(1, 0, 0, 2, 5'h04, 0, 32'h0000, 0);
      op(1, 0, 0, 2, 5'h04, 1, 32'h0001, 0);
      op(1, 0, 0, 3, 5'h1E, 1, 32'h0001_8000, 0);
      op(5, 0, 1, 3, 5'h04, 1, 32'h0001, 0);
      op(5, 0, 0, 3, 5'h04, 1, 32'h0000, 1);
      op(6, 0, 1, 3, 5'h04, 1, 32'h0003, 0);
      op(6, 0, 0, 0, 5'h04, 1, 32'h7FFF, 1);
      op(7, 0, 3, 3, 5'h04, 1, 32'h0012, 0);
      op(7, 0, 0, 3, 5'h04, 1, 32'h8000, 1);
      op(7, 0, 0, 3, 5'h1A, 1, 32'hFFFD_0000, 0);
      op(8, 0, 0, 3, 5'h04, 1, 32'hFFFF, 0);
      op(8, 0, 0, 3, 5'h04, 0, 32'hFFFE, 0);
      op(0, 1, 0, 0, 5'h0D, 1, 32'hC000, 0);
      op(0, 0, 0, 0, 5'h1C, 1, 32'h7FFF_FFFF, 1);
      op(2, 1, 3, 0, 5'h1E, 1, 32'h0001_8000, 0);
      $display("test modes done");
      bad(0, 1, 0, 5'h06);
      bad(2, 1, 0, 5'h18);
      for (int k = 3; k < 9; k++) begin
         if (k != 7) bad(k[3:0], 0, 0, 5'h18);
      end
      bad(4'hF, 0, 0, 5'h04);
      rd(4, 32'h0001_8000);
      $display("test refusal done");
      mul16_decoder_model_inst.clear_sticky();
      @(negedge clk_i);
      exp_sticky = 1'b0;
      chk("sticky_clear", 32'h0, {31'h0, sticky});
      op(2, 0, 3, 3, 5'h04, 1, 32'h0009, 0);
      $display("test sticky done");
      wrap_up();
   end

endmodule : test_mul16_operand_multiplier
